// ---- design/lcbml_top.v ----
// Lifecycle and boot mode guard with Avalon-MM register slave
//
// The placing of the registers and register access over Avalon-MM are this design's own decisions.
`timescale 1ns/1ps
`include "lcbml_defines.vh"

module lcbml_top #(
   parameter [31:0] TEST_PASSWORD = 32'h5A3C_96E1, // Arbitrary value
   parameter [1:0] AUTH_MAX_FAIL = 2'h3
) (
   // Clock and reset
   input wire clk_in,
   input wire sys_rst_in,
   // Avalon-MM slave
   input wire [`LCBML_ADDR_W-1:0] avs_address_in,
   input wire avs_read_in,
   input wire avs_write_in,
   input wire [31:0] avs_writedata_in,
   input wire [3:0] avs_byteenable_in,
   output reg [31:0] avs_readdata_out,
   output wire avs_waitrequest_out,
   // Non-volatile state storage
   input wire [`LCBML_NV_W-1:0] nv_state_in,
   output reg [`LCBML_NV_W-1:0] nv_state_out,
   output reg nv_write_out,
   // Test mode command gate
   input wire test_cmd_req_in,
   output wire test_cmd_grant_out,
   output wire test_cmd_refuse_out,
   // Manufacturing functional test gate
   input wire func_test_req_in,
   output wire func_test_grant_out,
   output wire func_test_refuse_out,
   // Loader command gate
   input wire loader_cmd_req_in,
   input wire [`LCBML_CMD_W-1:0] loader_cmd_code_in,
   output wire loader_cmd_grant_out,
   output wire loader_cmd_refuse_out,
   // Flash write gate
   input wire flash_wr_req_in,
   output wire flash_wr_grant_out,
   output wire flash_wr_refuse_out,
   // ROM access gate
   input wire rom_acc_req_in,
   output wire rom_acc_grant_out,
   output wire rom_acc_refuse_out,
   // Traceability write gate
   input wire trace_wr_req_in,
   output wire trace_wr_grant_out,
   output wire trace_wr_refuse_out,
   // Mode indications
   output reg rom_boot_out,
   output reg flash_boot_out,
   output reg normal_mode_out,
   output reg loader_enable_out
);

   // =======================================================
   // Protection state
   reg loaded;
   reg lc_normal;
   reg test_auth;
   reg boot_flash;
   reg boot_lock;
   reg rom_hidden;
   reg flash_ro;
   reg [`LCBML_FAIL_W-1:0] fail_count;
   reg [`LCBML_RF_W-1:0] refused;
   reg rd_ready;

   wire auth_blocked;
   wire bus_wr;
   wire bus_rd;
   wire ctl_wr;
   wire pwd_wr;
   wire rf_wr;
   wire loader_flash_cmd;
   wire [`LCBML_NV_W-1:0] nv_image;
   wire [`LCBML_RF_W-1:0] refuse_events;
   wire test_allow;
   wire func_allow;
   wire loader_allow;
   wire flash_allow;
   wire rom_allow;
   wire trace_allow;
   reg [31:0] next_readdata;

   assign auth_blocked = (fail_count == AUTH_MAX_FAIL);

   // =======================================================
   // Bus decode
   // Reads take one wait state so read data comes from a flop
   assign avs_waitrequest_out = ~loaded | (avs_read_in & ~rd_ready);
   assign bus_wr = avs_write_in & loaded;
   assign bus_rd = avs_read_in & loaded & ~rd_ready;
   assign ctl_wr = bus_wr & (avs_address_in == `LCBML_REG_CONTROL) & avs_byteenable_in[0];
   assign rf_wr = bus_wr & (avs_address_in == `LCBML_REG_REFUSED) & avs_byteenable_in[0];
   // Partial password writes are dropped, never counted as attempts
   assign pwd_wr = bus_wr & (avs_address_in == `LCBML_REG_PASSWORD) &
      (avs_byteenable_in == `LCBML_BE_ALL);

   // =======================================================
   // Access gates
   assign test_allow = loaded & ~lc_normal & test_auth;
   assign func_allow = loaded & ~lc_normal & test_auth;

   assign loader_flash_cmd = (loader_cmd_code_in == `LCBML_CMD_FLASH_READ) |
      (loader_cmd_code_in == `LCBML_CMD_FLASH_DOWNLOAD) |
      (loader_cmd_code_in == `LCBML_CMD_FLASH_MODIFY);
   // Flash boot alone already shuts the loader; the lock term keeps flash
   // commands dead even if the boot bit were ever upset
   assign loader_allow = loaded & ~boot_flash &
      ~(boot_lock & loader_flash_cmd);

   // Write data on this path is ciphertext from the loading party; the
   // gate only decides whether the write may proceed
   assign flash_allow = loaded & ~flash_ro;
   assign rom_allow = loaded & ~rom_hidden;
   assign trace_allow = loaded & ~lc_normal;

   lcbml_gate test_gate_u (
      .req_in(test_cmd_req_in),
      .allow_in(test_allow),
      .grant_out(test_cmd_grant_out),
      .refuse_out(test_cmd_refuse_out)
   );
   lcbml_gate func_gate_u (
      .req_in(func_test_req_in),
      .allow_in(func_allow),
      .grant_out(func_test_grant_out),
      .refuse_out(func_test_refuse_out)
   );
   lcbml_gate loader_gate_u (
      .req_in(loader_cmd_req_in),
      .allow_in(loader_allow),
      .grant_out(loader_cmd_grant_out),
      .refuse_out(loader_cmd_refuse_out)
   );
   lcbml_gate flash_gate_u (
      .req_in(flash_wr_req_in),
      .allow_in(flash_allow),
      .grant_out(flash_wr_grant_out),
      .refuse_out(flash_wr_refuse_out)
   );
   lcbml_gate rom_gate_u (
      .req_in(rom_acc_req_in),
      .allow_in(rom_allow),
      .grant_out(rom_acc_grant_out),
      .refuse_out(rom_acc_refuse_out)
   );
   lcbml_gate trace_gate_u (
      .req_in(trace_wr_req_in),
      .allow_in(trace_allow),
      .grant_out(trace_wr_grant_out),
      .refuse_out(trace_wr_refuse_out)
   );

   assign refuse_events[`LCBML_RF_TEST] = test_cmd_refuse_out | func_test_refuse_out;
   assign refuse_events[`LCBML_RF_LOADER] = loader_cmd_refuse_out;
   assign refuse_events[`LCBML_RF_FLASH_WR] = flash_wr_refuse_out;
   assign refuse_events[`LCBML_RF_ROM] = rom_acc_refuse_out;
   assign refuse_events[`LCBML_RF_TRACE] = trace_wr_refuse_out;

   // =======================================================
   // Reload from non-volatile storage
   // Async reset loads safe constants; the stored image is taken on the
   // first edge after release, and the block stays closed until then
   always @(posedge clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         loaded <= 1'b0;
      end else begin
         loaded <= 1'b1;
      end
   end

   // =======================================================
   // Lifecycle and authentication
   always @(posedge clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         lc_normal <= 1'b0;
         test_auth <= 1'b0;
         fail_count <= {`LCBML_FAIL_W{1'b0}};
      end else if (~loaded) begin
         lc_normal <= nv_state_in[`LCBML_NV_NORMAL];
         test_auth <= 1'b0;
         fail_count <= {`LCBML_FAIL_W{1'b0}};
      end else begin
         if (ctl_wr & avs_writedata_in[`LCBML_CT_GO_NORMAL]) begin
            lc_normal <= 1'b1;
         end
         // No clear path exists for lc_normal, which makes it one-way
         if (lc_normal | (ctl_wr & avs_writedata_in[`LCBML_CT_GO_NORMAL])) begin
            test_auth <= 1'b0;
         end else if (pwd_wr & ~auth_blocked) begin
            if (avs_writedata_in == TEST_PASSWORD) begin
               test_auth <= 1'b1;
               fail_count <= {`LCBML_FAIL_W{1'b0}};
            end else begin
               test_auth <= 1'b0;
               fail_count <= fail_count + {{(`LCBML_FAIL_W-1){1'b0}}, 1'b1};
            end
         end
      end
   end

   // =======================================================
   // Boot selection and memory attributes
   always @(posedge clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         boot_flash <= 1'b0;
         boot_lock <= 1'b0;
         rom_hidden <= 1'b0;
         flash_ro <= 1'b0;
      end else if (~loaded) begin
         boot_flash <= nv_state_in[`LCBML_NV_BOOT_FLASH];
         // A lock is only meaningful together with flash boot
         boot_lock <= nv_state_in[`LCBML_NV_BOOT_LOCK] & nv_state_in[`LCBML_NV_BOOT_FLASH];
         rom_hidden <= nv_state_in[`LCBML_NV_ROM_HIDDEN];
         flash_ro <= nv_state_in[`LCBML_NV_FLASH_RO];
      end else if (ctl_wr) begin
         // One bit holds the choice, so ROM and flash boot stay exclusive
         if (~boot_lock) begin
            if (avs_writedata_in[`LCBML_CT_SEL_FLASH]) begin
               boot_flash <= 1'b1;
            end else if (avs_writedata_in[`LCBML_CT_SEL_ROM]) begin
               boot_flash <= 1'b0;
            end
         end
         // Lock needs flash boot already in place
         if (avs_writedata_in[`LCBML_CT_LOCK_BOOT] & boot_flash) begin
            boot_lock <= 1'b1;
         end
         if (avs_writedata_in[`LCBML_CT_HIDE_ROM]) begin
            rom_hidden <= 1'b1;
         end
         // Set wins over clear; clearing is not allowed once locked
         if (avs_writedata_in[`LCBML_CT_SET_FLASH_RO]) begin
            flash_ro <= 1'b1;
         end else if (avs_writedata_in[`LCBML_CT_CLR_FLASH_RO] & ~boot_lock) begin
            flash_ro <= 1'b0;
         end
      end
   end

   // =======================================================
   // Refusal flags, new events win over a clear
   always @(posedge clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         refused <= {`LCBML_RF_W{1'b0}};
      end else if (rf_wr) begin
         refused <= (refused & ~avs_writedata_in[`LCBML_RF_W-1:0]) | refuse_events;
      end else begin
         refused <= refused | refuse_events;
      end
   end

   // =======================================================
   // Non-volatile write back
   assign nv_image[`LCBML_NV_NORMAL] = lc_normal;
   assign nv_image[`LCBML_NV_BOOT_FLASH] = boot_flash;
   assign nv_image[`LCBML_NV_BOOT_LOCK] = boot_lock;
   assign nv_image[`LCBML_NV_ROM_HIDDEN] = rom_hidden;
   assign nv_image[`LCBML_NV_FLASH_RO] = flash_ro;

   always @(posedge clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         nv_state_out <= {`LCBML_NV_W{1'b0}};
         nv_write_out <= 1'b0;
      end else if (~loaded) begin
         nv_state_out <= nv_state_in;
         nv_write_out <= 1'b0;
      end else begin
         // Pulse one cycle whenever the held image changes
         nv_state_out <= nv_image;
         nv_write_out <= (nv_image != nv_state_out);
      end
   end

   // =======================================================
   // Mode indications
   always @(posedge clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         rom_boot_out <= 1'b0;
         flash_boot_out <= 1'b0;
         normal_mode_out <= 1'b0;
         loader_enable_out <= 1'b0;
      end else begin
         rom_boot_out <= loaded & ~boot_flash;
         flash_boot_out <= loaded & boot_flash;
         normal_mode_out <= loaded & lc_normal;
         loader_enable_out <= loaded & ~boot_flash;
      end
   end

   // =======================================================
   // Read path
   always @* begin
      next_readdata = `LCBML_ZERO32;
      case (avs_address_in)
         `LCBML_REG_STATUS: begin
            next_readdata[`LCBML_ST_NORMAL] = lc_normal;
            next_readdata[`LCBML_ST_TEST_AUTH] = test_auth;
            next_readdata[`LCBML_ST_BOOT_FLASH] = boot_flash;
            next_readdata[`LCBML_ST_BOOT_LOCK] = boot_lock;
            next_readdata[`LCBML_ST_ROM_HIDDEN] = rom_hidden;
            next_readdata[`LCBML_ST_FLASH_RO] = flash_ro;
            next_readdata[`LCBML_ST_AUTH_BLOCKED] = auth_blocked;
            next_readdata[`LCBML_ST_LOADED] = loaded;
            next_readdata[`LCBML_ST_FAIL_MSB:`LCBML_ST_FAIL_LSB] = fail_count;
         end
         `LCBML_REG_REFUSED: begin
            next_readdata[`LCBML_RF_W-1:0] = refused;
         end
         // Control and password read as zero so the secret never leaks
         default: begin
            next_readdata = `LCBML_ZERO32;
         end
      endcase
   end

   always @(posedge clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         rd_ready <= 1'b0;
         avs_readdata_out <= `LCBML_ZERO32;
      end else begin
         rd_ready <= bus_rd;
         if (bus_rd) begin
            avs_readdata_out <= next_readdata;
         end
      end
   end

endmodule

// ==========================================================
// Request gate, exactly one answer while a request stands
module lcbml_gate (
   // Request and permission
   input wire req_in,
   input wire allow_in,
   // Answer
   output wire grant_out,
   output wire refuse_out
);

   assign grant_out = req_in & allow_in;
   assign refuse_out = req_in & ~allow_in;

endmodule

// ---- design/lcbml_defines.vh ----
// Constants for the lifecycle and boot mode guard
`ifndef LCBML_DEFINES_VH
`define LCBML_DEFINES_VH

// ==========================================================
// Register byte offsets
`define LCBML_ADDR_W 4
`define LCBML_REG_STATUS 4'h0
`define LCBML_REG_CONTROL 4'h4
`define LCBML_REG_PASSWORD 4'h8
`define LCBML_REG_REFUSED 4'hC

// ==========================================================
// Status register fields
`define LCBML_ST_NORMAL 0
`define LCBML_ST_TEST_AUTH 1
`define LCBML_ST_BOOT_FLASH 2
`define LCBML_ST_BOOT_LOCK 3
`define LCBML_ST_ROM_HIDDEN 4
`define LCBML_ST_FLASH_RO 5
`define LCBML_ST_AUTH_BLOCKED 6
`define LCBML_ST_LOADED 7
`define LCBML_ST_FAIL_LSB 8
`define LCBML_ST_FAIL_MSB 9

// ==========================================================
// Control register command bits (write one to act)
`define LCBML_CT_GO_NORMAL 0
`define LCBML_CT_SEL_FLASH 1
`define LCBML_CT_SEL_ROM 2
`define LCBML_CT_LOCK_BOOT 3
`define LCBML_CT_HIDE_ROM 4
`define LCBML_CT_SET_FLASH_RO 5
`define LCBML_CT_CLR_FLASH_RO 6

// ==========================================================
// Refusal flags (write one to clear)
`define LCBML_RF_W 5
`define LCBML_RF_TEST 0
`define LCBML_RF_LOADER 1
`define LCBML_RF_FLASH_WR 2
`define LCBML_RF_ROM 3
`define LCBML_RF_TRACE 4

// ==========================================================
// Non-volatile image layout
`define LCBML_NV_W 5
`define LCBML_NV_NORMAL 0
`define LCBML_NV_BOOT_FLASH 1
`define LCBML_NV_BOOT_LOCK 2
`define LCBML_NV_ROM_HIDDEN 3
`define LCBML_NV_FLASH_RO 4

// ==========================================================
// Loader command codes
`define LCBML_CMD_W 3
`define LCBML_CMD_FLASH_READ 3'h1
`define LCBML_CMD_FLASH_DOWNLOAD 3'h2
`define LCBML_CMD_FLASH_MODIFY 3'h3

// ==========================================================
// Misc values
`define LCBML_FAIL_W 2
`define LCBML_ZERO32 32'h0000_0000
`define LCBML_BE_ALL 4'hF

`endif

// ---- verif/lcbml_checker_assertions.sv ----
// Concurrent assertions for the lifecycle and boot mode guard
`timescale 1ns/1ps
`include "lcbml_defines.vh"
module lcbml_checker (
   // Clock, reset and bus
   input wire clk_in, sys_rst_in, avs_write_in,
   // Stored image
   input wire [`LCBML_NV_W-1:0] nv_state_out,
   // Gates
   input wire func_test_req_in, func_test_grant_out, test_cmd_req_in, test_cmd_grant_out,
   input wire loader_cmd_req_in, loader_cmd_refuse_out,
   input wire [`LCBML_CMD_W-1:0] loader_cmd_code_in,
   input wire flash_wr_req_in, flash_wr_refuse_out, rom_acc_req_in, rom_acc_refuse_out,
   input wire trace_wr_req_in, trace_wr_refuse_out,
   // Mode indications
   input wire rom_boot_out, flash_boot_out
);
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (sys_rst_in);
   // ==========================================================
   // Gates, stored image and boot indications; the image may still lag a write just taken
   chk_test_refused: assert property (
      nv_state_out[`LCBML_NV_NORMAL] && test_cmd_req_in |-> !test_cmd_grant_out)
      else $error("test command granted in normal mode");
   chk_normal_kept: assert property (
      nv_state_out[`LCBML_NV_NORMAL] |=> nv_state_out[`LCBML_NV_NORMAL])
      else $error("normal lifecycle left");
   chk_func_blocked: assert property (
      nv_state_out[`LCBML_NV_NORMAL] && func_test_req_in |-> !func_test_grant_out)
      else $error("functional test granted in normal mode");
   chk_boot_single: assert property (
      rom_boot_out || flash_boot_out |-> rom_boot_out != flash_boot_out)
      else $error("both boot selections active");
   chk_loader_off: assert property (
      flash_boot_out && !$past(avs_write_in) && loader_cmd_req_in |-> loader_cmd_refuse_out)
      else $error("loader command taken in flash boot");
   chk_lock_kept: assert property (
      nv_state_out[`LCBML_NV_BOOT_LOCK] |=> nv_state_out[`LCBML_NV_BOOT_LOCK]
      && $stable(nv_state_out[`LCBML_NV_BOOT_FLASH]))
      else $error("locked boot selection changed");
   chk_lock_cmds: assert property (
      nv_state_out[`LCBML_NV_BOOT_LOCK] && loader_cmd_req_in && loader_cmd_code_in != 3'h0
      && loader_cmd_code_in <= `LCBML_CMD_FLASH_MODIFY |-> loader_cmd_refuse_out)
      else $error("flash loader command taken while locked");
   chk_rom_blocked: assert property (
      nv_state_out[`LCBML_NV_ROM_HIDDEN] && rom_acc_req_in |-> rom_acc_refuse_out)
      else $error("hidden ROM accessed");
   chk_flash_ro: assert property (
      nv_state_out[`LCBML_NV_FLASH_RO] && !$past(avs_write_in) && flash_wr_req_in
      |-> flash_wr_refuse_out)
      else $error("flash write under read-only");
   chk_trace_ro: assert property (
      nv_state_out[`LCBML_NV_NORMAL] && trace_wr_req_in |-> trace_wr_refuse_out)
      else $error("trace write in normal mode");
endmodule

bind lcbml_top lcbml_checker chk_u (.clk_in(clk_in), .sys_rst_in(sys_rst_in),
   .avs_write_in(avs_write_in), .nv_state_out(nv_state_out),
   .func_test_req_in(func_test_req_in), .func_test_grant_out(func_test_grant_out),
   .test_cmd_req_in(test_cmd_req_in), .test_cmd_grant_out(test_cmd_grant_out),
   .loader_cmd_req_in(loader_cmd_req_in), .loader_cmd_refuse_out(loader_cmd_refuse_out),
   .loader_cmd_code_in(loader_cmd_code_in), .flash_wr_req_in(flash_wr_req_in),
   .flash_wr_refuse_out(flash_wr_refuse_out), .rom_acc_req_in(rom_acc_req_in),
   .rom_acc_refuse_out(rom_acc_refuse_out), .trace_wr_req_in(trace_wr_req_in),
   .trace_wr_refuse_out(trace_wr_refuse_out), .rom_boot_out(rom_boot_out),
   .flash_boot_out(flash_boot_out));

// ---- verif/lcbml_host_model.sv ----
// Tester and loader host that raises gate requests
`timescale 1ns/1ps
module lcbml_host_model (
   // Clock
   input wire clk_in,
   // Answers: test, func, loader, flash, rom, trace
   input wire [5:0] grant_in,
   input wire [5:0] refuse_in,
   // Requests
   output reg [5:0] req_out,
   output reg [2:0] code_out
);
   initial begin
      req_out = 6'h00;
      code_out = 3'h7;
   end
   // Flash data would travel as ciphertext only; no plaintext path exists here
   task request(input integer k, input [2:0] c, output g, output r);
      begin
         @(posedge clk_in);
         req_out <= 6'h01 << k;
         code_out <= c;
         @(posedge clk_in);
         g = grant_in[k];
         r = refuse_in[k];
         req_out <= 6'h00;
         // Released code shows the inverse of the last value, never the value itself
         code_out <= ~c;
      end
   endtask
endmodule

// ---- verif/lifecycle_boot_mode_lock_bench.sv ----
// Self-checking bench for the lifecycle and boot mode guard
`timescale 1ns/1ps
`include "lcbml_defines.vh"
module lifecycle_boot_mode_lock_bench;
   localparam [31:0] PW = 32'h1234_ABCD; // Arbitrary value
   reg clk_in = 1'b0;
   reg sys_rst_in = 1'b1;
   reg [3:0] avs_address_in = 4'h0;
   reg avs_read_in = 1'b0;
   reg avs_write_in = 1'b0;
   reg [31:0] avs_writedata_in = 32'h0;
   reg [3:0] avs_byteenable_in = 4'h0;
   reg [4:0] nv_state_in = 5'h00;
   wire [31:0] avs_readdata_out;
   wire avs_waitrequest_out, nv_write_out;
   wire [4:0] nv_state_out;
   wire [5:0] rq, gr, rf;
   wire [2:0] code;
   wire rom_boot_out, flash_boot_out, normal_mode_out, loader_enable_out;
   integer n_errors = 0;
   integer checked = 0;
   integer c;
   reg [31:0] q;

   lcbml_top #(.TEST_PASSWORD(PW)) dut_u (.clk_in(clk_in), .sys_rst_in(sys_rst_in),
      .avs_address_in(avs_address_in), .avs_read_in(avs_read_in),
      .avs_write_in(avs_write_in), .avs_writedata_in(avs_writedata_in),
      .avs_byteenable_in(avs_byteenable_in), .avs_readdata_out(avs_readdata_out),
      .avs_waitrequest_out(avs_waitrequest_out), .nv_state_in(nv_state_in),
      .nv_state_out(nv_state_out), .nv_write_out(nv_write_out),
      .test_cmd_req_in(rq[0]), .test_cmd_grant_out(gr[0]), .test_cmd_refuse_out(rf[0]),
      .func_test_req_in(rq[1]), .func_test_grant_out(gr[1]), .func_test_refuse_out(rf[1]),
      .loader_cmd_req_in(rq[2]), .loader_cmd_code_in(code),
      .loader_cmd_grant_out(gr[2]), .loader_cmd_refuse_out(rf[2]),
      .flash_wr_req_in(rq[3]), .flash_wr_grant_out(gr[3]), .flash_wr_refuse_out(rf[3]),
      .rom_acc_req_in(rq[4]), .rom_acc_grant_out(gr[4]), .rom_acc_refuse_out(rf[4]),
      .trace_wr_req_in(rq[5]), .trace_wr_grant_out(gr[5]), .trace_wr_refuse_out(rf[5]),
      .rom_boot_out(rom_boot_out), .flash_boot_out(flash_boot_out),
      .normal_mode_out(normal_mode_out), .loader_enable_out(loader_enable_out));
   lcbml_host_model host_u (.clk_in(clk_in), .grant_in(gr), .refuse_in(rf), .req_out(rq),
      .code_out(code));

   always #25 clk_in = ~clk_in;

   // ==========================================================
   // Shared tasks
   task finish_test;
      begin
         if (n_errors == 0 && checked > 0)
            $display("[ PASS ]");
         else
            $display("[ FAIL ]");
         $finish;
      end
   endtask
   task check(input [31:0] seen, input [31:0] exp);
      begin
         checked = checked + 1;
         if (seen !== exp) begin
            n_errors = n_errors + 1;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
         end
      end
   endtask
   // Request stands until the rising edge that sees waitrequest low
   task bus(input w, input [3:0] a, input [31:0] d);
      begin
         @(posedge clk_in);
         avs_address_in <= a;
         avs_writedata_in <= d;
         avs_write_in <= w;
         avs_read_in <= !w;
         avs_byteenable_in <= 4'hF;
         @(posedge clk_in);
         while (avs_waitrequest_out !== 1'b0)
            @(posedge clk_in);
         q = avs_readdata_out;
         avs_write_in <= 1'b0;
         avs_read_in <= 1'b0;
      end
   endtask
   task st(input [31:0] e);
      begin
         bus(1'b0, `LCBML_REG_STATUS, 32'h0);
         check(q, e);
      end
   endtask
   task gate(input integer k, input [2:0] cd, input e);
      reg g, r;
      begin
         host_u.request(k, cd, g, r);
         check({g, r}, {e, !e});
      end
   endtask

   // ==========================================================
   // Scenarios
   task t_auth;
      begin
         st(32'h80);
         check({rom_boot_out, flash_boot_out}, 2'b10);
         check(loader_enable_out, 1'b1);
         check(normal_mode_out, 1'b0);
         gate(5, 3'h0, 1'b1);
         gate(0, 3'h0, 1'b0);
         bus(1'b1, `LCBML_REG_PASSWORD, ~PW);
         st(32'h180);
         gate(1, 3'h0, 1'b0);
         bus(1'b1, `LCBML_REG_PASSWORD, PW);
         bus(1'b0, `LCBML_REG_PASSWORD, 32'h0);
         check(q, 32'h0);
         st(32'h82);
         gate(0, 3'h0, 1'b1);
         gate(1, 3'h0, 1'b1);
      end
   endtask
   task t_attrs;
      begin
         bus(1'b1, `LCBML_REG_CONTROL, 32'h20);
         gate(3, 3'h0, 1'b0);
         bus(1'b1, `LCBML_REG_CONTROL, 32'h40);
         gate(3, 3'h0, 1'b1);
         gate(4, 3'h0, 1'b1);
         bus(1'b1, `LCBML_REG_CONTROL, 32'h10);
         // Image changes at the write, pulse one edge later
         repeat (2) @(posedge clk_in);
         check(nv_write_out, 1'b1);
         @(posedge clk_in);
         check(nv_write_out, 1'b0);
         gate(4, 3'h0, 1'b0);
         st(32'h92);
         bus(1'b0, `LCBML_REG_REFUSED, 32'h0);
         check(q, 32'h0D);
         bus(1'b1, `LCBML_REG_REFUSED, 32'h1F);
         bus(1'b0, `LCBML_REG_REFUSED, 32'h0);
         check(q, 32'h0);
      end
   endtask
   task t_boot;
      begin
         for (c = 1; c < 8; c = c + 1)
            gate(2, c[2:0], 1'b1);
         bus(1'b1, `LCBML_REG_CONTROL, 32'h02);
         gate(2, 3'h5, 1'b0);
         check({rom_boot_out, flash_boot_out}, 2'b01);
         check(loader_enable_out, 1'b0);
         bus(1'b1, `LCBML_REG_CONTROL, 32'h04);
         gate(2, 3'h1, 1'b1);
         bus(1'b1, `LCBML_REG_CONTROL, 32'h02);
         bus(1'b1, `LCBML_REG_CONTROL, 32'h08);
         bus(1'b1, `LCBML_REG_CONTROL, 32'h04);
         bus(1'b1, `LCBML_REG_CONTROL, 32'h20);
         bus(1'b1, `LCBML_REG_CONTROL, 32'h40);
         st(32'hBE);
         for (c = 1; c < 4; c = c + 1)
            gate(2, c[2:0], 1'b0);
         gate(3, 3'h0, 1'b0);
         check({rom_boot_out, flash_boot_out}, 2'b01);
      end
   endtask
   task t_normal;
      begin
         bus(1'b1, `LCBML_REG_CONTROL, 32'h01);
         gate(0, 3'h0, 1'b0);
         gate(1, 3'h0, 1'b0);
         gate(5, 3'h0, 1'b0);
         bus(1'b1, `LCBML_REG_PASSWORD, PW);
         bus(1'b1, `LCBML_REG_CONTROL, 32'h00);
         st(32'hBD);
         check(normal_mode_out, 1'b1);
         gate(0, 3'h0, 1'b0);
         check(nv_state_out, 5'h1F);
      end
   endtask
   task t_reload;
      begin
         @(posedge clk_in);
         sys_rst_in <= 1'b1;
         nv_state_in <= 5'h1F;
         repeat (2) @(posedge clk_in);
         sys_rst_in <= 1'b0;
         st(32'hBD);
         gate(4, 3'h0, 1'b0);
         gate(2, 3'h4, 1'b0);
         gate(0, 3'h0, 1'b0);
      end
   endtask

   initial begin
      repeat (6) @(posedge clk_in);
      sys_rst_in <= 1'b0;
      t_auth;
      t_attrs;
      t_boot;
      t_normal;
      t_reload;
      finish_test;
   end
   initial begin
      #(50 * 4000);
      n_errors = n_errors + 1;
      finish_test;
   end
endmodule
